// *** psw_pkg.sv ***
package psw_pkg;

    localparam logic [7:0] PSW_ADDR      = 8'hd0;
    localparam logic [7:0] PSW_RESET     = 8'h00;
    localparam int         CARRY_BIT     = 7;
    localparam int         HALF_BIT      = 6;
    localparam int         USER0_BIT     = 5;
    localparam int         BANK_HI_BIT   = 4;
    localparam int         BANK_LO_BIT   = 3;
    localparam int         OVER_BIT      = 2;
    localparam int         USER1_BIT     = 1;
    localparam int         PARITY_BIT    = 0;
    localparam logic [8:0] BYTE_LIMIT    = 9'h0ff;
    localparam logic [7:0] BANK_BYTES    = 8'h08;

    typedef enum logic [2:0] {
        PSW_OP_NONE       = 3'h0,
        PSW_OP_ADD        = 3'h1,
        PSW_OP_ADD_CARRY  = 3'h3,
        PSW_OP_SUB_BORROW = 3'h2,
        PSW_OP_MULTIPLY   = 3'h6,
        PSW_OP_DIV        = 3'h7,
        PSW_OP_OTHER      = 3'h5
    } psw_op_t;

    typedef struct packed {
        psw_op_t    op;
        logic [7:0] lhs;
        logic [7:0] rhs;
    } psw_alu_t;

    typedef struct packed {
        logic       carry;
        logic       half;
        logic       user0;
        logic [1:0] bank;
        logic       over;
        logic       user1;
    } psw_state_t;

    typedef struct packed {
        logic       byteWr;
        logic       bitWr;
        logic [7:0] addr;
        logic [2:0] bitIdx;
        logic [7:0] wdata;
    } psw_sfr_t;

endpackage

// *** psw_parity.sv ***
module psw_parity #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] value,
    output logic                  odd
);

    assign odd = ^value;

endmodule

// *** psw_status_word.sv ***
// Operation
// - Carry set on carry or borrow
// - Half carry set on nibble carry
// - Two user flags changed only by software
// - Bank select picks register bank base
// - Overflow set on signed add/sub overflow
// - Overflow set when product exceeds 255
// - Overflow set on divide by zero
// - Overflow cleared otherwise by these ops
// - Parity shows odd count of accumulator ones
// - Word at address 0xD0, byte and bit
// - Bank holds eight registers in 0x00-0x1F
// - Parity taken from the accumulator
module psw_status_word (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire psw_pkg::psw_alu_t alu,
    input  wire logic [7:0]        accumulatorReg,
    input  wire psw_pkg::psw_sfr_t sfr,
    output logic [7:0]             programStatusWord,
    output logic [7:0]             bankBase,
    output logic                   carryFlag
);

    typedef struct packed {
        psw_pkg::psw_state_t st;
        logic [7:0]          rdata;
        logic [7:0]          base;
    } psw_regs_t;

    psw_regs_t   r_q;
    psw_regs_t   r_d;
    logic        parityNow;
    logic [8:0]  sum;
    logic [4:0]  nib;
    logic [15:0] prod;
    logic        cin;
    logic        addLike;
    logic        subLike;
    logic        hit;
    logic [7:0]  wordNow;
    logic [7:0]  wordWr;

    psw_parity #(
        .WIDTH(8)
    ) u_parity (
        .value(accumulatorReg),
        .odd  (parityNow)
    );

    always_comb
    begin
        r_d = r_q;
        cin = (alu.op == psw_pkg::PSW_OP_ADD) ? 1'b0 : r_q.st.carry;
        addLike = (alu.op == psw_pkg::PSW_OP_ADD) || (alu.op == psw_pkg::PSW_OP_ADD_CARRY);
        subLike = (alu.op == psw_pkg::PSW_OP_SUB_BORROW);
        sum = 9'h000;
        nib = 5'h00;
        if (addLike)
        begin
            sum = {1'b0, alu.lhs} + {1'b0, alu.rhs} + {8'h00, cin};
            nib = {1'b0, alu.lhs[3:0]} + {1'b0, alu.rhs[3:0]} + {4'h0, cin};
        end
        else if (subLike)
        begin
            sum = {1'b0, alu.lhs} - {1'b0, alu.rhs} - {8'h00, cin};
            nib = {1'b0, alu.lhs[3:0]} - {1'b0, alu.rhs[3:0]} - {4'h0, cin};
        end
        prod = alu.lhs * alu.rhs;
        wordNow = {r_q.st.carry, r_q.st.half, r_q.st.user0, r_q.st.bank,
                   r_q.st.over, r_q.st.user1, parityNow};
        hit = (sfr.addr == psw_pkg::PSW_ADDR);
        // Arithmetic flag update
        // Overflow cleared otherwise by these ops, held on other ops
        if (addLike || subLike)
        begin
            r_d.st.carry = sum[8];
            r_d.st.half = nib[4];
            if (addLike)
                r_d.st.over = (alu.lhs[7] == alu.rhs[7]) && (sum[7] != alu.lhs[7]);
            else
                r_d.st.over = (alu.lhs[7] != alu.rhs[7]) && (sum[7] != alu.lhs[7]);
        end
        else if (alu.op == psw_pkg::PSW_OP_MULTIPLY)
        begin
            r_d.st.over = (prod > {7'h00, psw_pkg::BYTE_LIMIT});
            r_d.st.carry = 1'b0;
        end
        else if (alu.op == psw_pkg::PSW_OP_DIV)
        begin
            r_d.st.over = (alu.rhs == 8'h00);
            r_d.st.carry = 1'b0;
        end
        wordWr = wordNow;
        if (hit && sfr.byteWr)
            wordWr = sfr.wdata;
        else if (hit && sfr.bitWr)
            wordWr[sfr.bitIdx] = sfr.wdata[0];
        if (hit && (sfr.byteWr || sfr.bitWr))
        begin
            r_d.st.user0 = wordWr[psw_pkg::USER0_BIT];
            r_d.st.user1 = wordWr[psw_pkg::USER1_BIT];
            r_d.st.bank = wordWr[psw_pkg::BANK_HI_BIT:psw_pkg::BANK_LO_BIT];
            if (alu.op == psw_pkg::PSW_OP_NONE || alu.op == psw_pkg::PSW_OP_OTHER)
            begin
                r_d.st.carry = wordWr[psw_pkg::CARRY_BIT];
                r_d.st.half = wordWr[psw_pkg::HALF_BIT];
                r_d.st.over = wordWr[psw_pkg::OVER_BIT];
            end
        end
        r_d.rdata = {r_d.st.carry, r_d.st.half, r_d.st.user0, r_d.st.bank,
                     r_d.st.over, r_d.st.user1, 1'b0};
        r_d.rdata[psw_pkg::PARITY_BIT] = parityNow;
        r_d.base = {3'h0, r_d.st.bank, 3'h0};
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    assign programStatusWord = r_q.rdata;
    assign bankBase = r_q.base;
    assign carryFlag = r_q.st.carry;

    sequence s_addOp;
        alu.op == psw_pkg::PSW_OP_ADD;
    endsequence

    sequence s_subOp;
        alu.op == psw_pkg::PSW_OP_SUB_BORROW;
    endsequence

    sequence s_byteWrite;
        sfr.byteWr && (sfr.addr == psw_pkg::PSW_ADDR);
    endsequence

    property p_carry;
        @(posedge clock) disable iff (rst)
        s_addOp |=> carryFlag == (({1'b0, $past(alu.lhs)} + {1'b0, $past(alu.rhs)}) > 9'h0ff);
    endproperty
    a_carry: assert property (p_carry) else $error("carry wrong");

    property p_half;
        @(posedge clock) disable iff (rst)
        s_addOp |=> programStatusWord[6] ==
            (({1'b0, $past(alu.lhs[3:0])} + {1'b0, $past(alu.rhs[3:0])}) > 5'h0f);
    endproperty
    a_half: assert property (p_half) else $error("half carry wrong");

    property p_user;
        @(posedge clock) disable iff (rst)
        !(sfr.addr == psw_pkg::PSW_ADDR && (sfr.byteWr || sfr.bitWr))
        |=> $stable(programStatusWord[5]) && $stable(programStatusWord[1]);
    endproperty
    a_user: assert property (p_user) else $error("user flag changed");

    property p_bank;
        @(posedge clock) disable iff (rst)
        s_byteWrite |=> bankBase == {3'h0, $past(sfr.wdata[4:3]), 3'h0};
    endproperty
    a_bank: assert property (p_bank) else $error("bank base wrong");

    property p_ovAdd;
        @(posedge clock) disable iff (rst)
        (s_addOp and (alu.lhs == 8'h7f) and (alu.rhs == 8'h01)) |=> programStatusWord[2];
    endproperty
    a_ovAdd: assert property (p_ovAdd) else $error("add overflow missed");

    property p_ovSub;
        @(posedge clock) disable iff (rst)
        s_subOp |=> programStatusWord[2] ==
            (($past(alu.lhs[7]) != $past(alu.rhs[7])) &&
             ((($past(alu.lhs) - $past(alu.rhs) - $past(carryFlag)) & 8'h80) !=
              ($past(alu.lhs) & 8'h80)));
    endproperty
    a_ovSub: assert property (p_ovSub) else $error("subtract overflow wrong");

    property p_ovClear;
        @(posedge clock) disable iff (rst)
        (s_addOp and (alu.lhs[7] != alu.rhs[7])) |=> !programStatusWord[2];
    endproperty
    a_ovClear: assert property (p_ovClear) else $error("overflow not cleared");

    property p_ovMul;
        @(posedge clock) disable iff (rst)
        (alu.op == psw_pkg::PSW_OP_MULTIPLY) |=>
            programStatusWord[2] == (($past(alu.lhs) * $past(alu.rhs)) > 16'h00ff);
    endproperty
    a_ovMul: assert property (p_ovMul) else $error("multiply overflow wrong");

    property p_ovDiv;
        @(posedge clock) disable iff (rst)
        (alu.op == psw_pkg::PSW_OP_DIV) |=> programStatusWord[2] == ($past(alu.rhs) == 8'h00);
    endproperty
    a_ovDiv: assert property (p_ovDiv) else $error("divide overflow wrong");

    property p_parity;
        @(posedge clock) disable iff (rst)
        ##1 programStatusWord[0] == ^$past(accumulatorReg);
    endproperty
    a_parity: assert property (p_parity) else $error("parity wrong");

    property p_reset;
        @(posedge clock)
        rst |=> (programStatusWord[7:1] == 7'h00) && (bankBase == 8'h00) && !carryFlag;
    endproperty
    a_reset: assert property (p_reset) else $error("reset value wrong");

endmodule

// *** psw_core_model.sv ***
module psw_core_model (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              accWr,
    input  wire logic [7:0]        accIn,
    input  wire psw_pkg::psw_alu_t opIn,
    output psw_pkg::psw_alu_t      alu,
    output logic [7:0]             accumulatorReg
);
    always_ff @(posedge clock)
    begin
        if (rst)
            accumulatorReg <= 8'h00;
        else if (accWr)
            accumulatorReg <= accIn;
    end
    // Op strobe passes straight through
    assign alu = opIn;
endmodule

// *** tb_psw_status_word.sv ***
module tb_psw_status_word;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin errors++; \
        $display("unexpected %s exp %h got %h", n, e, s); end end
    typedef struct packed {
        logic [7:0] pre;
        logic [2:0] op;
        logic [7:0] lhs;
        logic [7:0] rhs;
        logic [7:0] exp;
    } psw_tb_row_t;
    logic              clock;
    logic              rst;
    logic              accWr;
    logic [7:0]        accIn;
    psw_pkg::psw_alu_t opIn;
    psw_pkg::psw_alu_t alu;
    psw_pkg::psw_sfr_t sfr;
    logic [7:0]        accumulatorReg;
    logic [7:0]        programStatusWord;
    logic [7:0]        bankBase;
    logic              carryFlag;
    int                errors;
    int                num_checks;
    psw_tb_row_t       rows [12];
    psw_core_model u_core (.clock(clock), .rst(rst), .accWr(accWr), .accIn(accIn),
        .opIn(opIn), .alu(alu), .accumulatorReg(accumulatorReg));
    psw_status_word u_dut (.clock(clock), .rst(rst), .alu(alu),
        .accumulatorReg(accumulatorReg), .sfr(sfr), .programStatusWord(programStatusWord),
        .bankBase(bankBase), .carryFlag(carryFlag));
    task automatic step();
        @(posedge clock);
        #2;
    endtask
    task automatic wr(input logic       b,
                      input logic [2:0] i,
                      input logic [7:0] a,
                      input logic [7:0] d);
        sfr = '{byteWr: b, bitWr: !b, addr: a, bitIdx: i, wdata: d};
        step();
        sfr = '0;
    endtask
    task automatic chk(input logic [7:0] e);
        `CHK("word", e, programStatusWord)
        `CHK("bank", {3'h0, e[4:3], 3'h0}, bankBase)
        `CHK("carry", e[7], carryFlag)
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial
    begin
        repeat (3000) @(posedge clock);
        errors++;
        test_done();
    end
    initial
    begin
        rows = '{'{8'h00, 3'h1, 8'h7f, 8'h01, 8'h44}, '{8'h00, 3'h1, 8'hff, 8'h01, 8'hc0},
            '{8'h80, 3'h3, 8'h00, 8'h00, 8'h00}, '{8'h80, 3'h3, 8'h7f, 8'h00, 8'h44},
            '{8'h00, 3'h2, 8'h00, 8'h01, 8'hc0}, '{8'h80, 3'h2, 8'h80, 8'h00, 8'h44},
            '{8'hc4, 3'h6, 8'h10, 8'h10, 8'h44}, '{8'hc4, 3'h6, 8'h0f, 8'h11, 8'h40},
            '{8'h00, 3'h7, 8'h05, 8'h00, 8'h04}, '{8'h04, 3'h7, 8'h05, 8'h01, 8'h00},
            '{8'h2a, 3'h1, 8'h01, 8'h01, 8'h2a}, '{8'h45, 3'h5, 8'hff, 8'hff, 8'h44}};
        errors = 0;
        num_checks = 0;
        rst = 1'b1;
        accWr = 1'b0;
        accIn = 8'h00;
        opIn = '0;
        sfr = '0;
        repeat (10) step();
        rst = 1'b0;
        chk(8'h00);
        $display("reset test done");
        foreach (rows[k])
        begin
            wr(1'b1, 3'h0, psw_pkg::PSW_ADDR, rows[k].pre);
            opIn = '{op: psw_pkg::psw_op_t'(rows[k].op), lhs: rows[k].lhs, rhs: rows[k].rhs};
            step();
            opIn = '0;
            chk(rows[k].exp);
        end
        $display("table test done");
        for (int b = 0; b < 4; b++)
        begin
            wr(1'b0, 3'h3, psw_pkg::PSW_ADDR, 8'(b % 2));
            step();
            wr(1'b0, 3'h4, psw_pkg::PSW_ADDR, 8'(b / 2));
            `CHK("bank", 8'(b * 8), bankBase)
        end
        wr(1'b0, 3'h0, psw_pkg::PSW_ADDR, 8'h01);
        step();
        wr(1'b1, 3'h0, 8'hd1, 8'hff);
        chk(8'h5c);
        opIn = '{op: psw_pkg::PSW_OP_ADD, lhs: 8'hff, rhs: 8'h01};
        wr(1'b1, 3'h0, psw_pkg::PSW_ADDR, 8'h22);
        opIn = '0;
        chk(8'he2);
        $display("write test done");
        for (int p = 0; p < 2; p++)
        begin
            accIn = p ? 8'h03 : 8'h07;
            accWr = 1'b1;
            step();
            accWr = 1'b0;
            step();
            `CHK("parity", !p, programStatusWord[0])
        end
        rst = 1'b1;
        step();
        rst = 1'b0;
        chk(8'h00);
        $display("parity and reset test done");
        test_done();
    end
endmodule
